// ==== pkg/pfx_consts.svh ====
`ifndef PFX_CONSTS_SVH
`define PFX_CONSTS_SVH

`define PFX_REG_BASE      16'h0180
`define PFX_BANK_STRIDE   16'h0010
`define PFX_EXC_VECTOR    8'h0a
`define PFX_BANK_ZERO     8'h00
`define PFX_XFER_CYCLES   4'h4
`define PFX_CCR_S_BIT     5
`define PFX_CCR_FLAG_MASK 8'h1f

`endif

// ==== pkg/pfx_pkg.sv ====
package pfx_pkg;

    typedef enum logic [3:0] {
        PFX_OP_PLAIN  = 4'h0,
        PFX_OP_PCB_P  = 4'h1,
        PFX_OP_DATA_P = 4'h2,
        PFX_OP_ADD_P  = 4'h3,
        PFX_OP_STK_P  = 4'h4,
        PFX_OP_CMN_P  = 4'h5,
        PFX_OP_FRZ_P  = 4'h6,
        PFX_OP_MOVLVL = 4'h7,
        PFX_OP_ORCC   = 4'h8,
        PFX_OP_ANDCC  = 4'h9,
        PFX_OP_POPSW  = 4'ha,
        PFX_OP_SWINT  = 4'hb,
        PFX_OP_DIVB   = 4'hc,
        PFX_OP_WORD_QUOTIENT_OP   = 4'hd,
        PFX_OP_UNDEF  = 4'he
    } pfx_op_t;

    typedef enum logic [2:0] {
        PFX_BANK_NONE = 3'h0,
        PFX_BANK_PROG = 3'h1,
        PFX_BANK_DATA = 3'h2,
        PFX_BANK_ADD  = 3'h3,
        PFX_BANK_STK  = 3'h4
    } pfx_bank_t;

    typedef enum logic [2:0] {
        PFX_IRQ_NONE = 3'h0,
        PFX_IRQ_HW   = 3'h1,
        PFX_IRQ_SW   = 3'h2,
        PFX_IRQ_XFER = 3'h3,
        PFX_IRQ_EXC  = 3'h4
    } pfx_irq_t;

    typedef enum logic [1:0] {
        PFX_ST_RUN  = 2'b00,
        PFX_ST_XFER = 2'b01
    } pfx_state_t;

endpackage : pfx_pkg

// ==== rtl/pfx_rem_addr.sv ====
`timescale 1ns/1ps
`include "pfx_consts.svh"

// remainder destination for byte/word divide on a general register
module pfx_rem_addr (
    input  wire logic       is_word,
    input  wire logic [2:0] reg_idx,
    input  wire logic [4:0] reg_bank_ptr,
    input  wire logic       cmn_bank,
    input  wire logic [7:0] data_bank,
    input  wire logic [7:0] add_bank,
    input  wire logic [7:0] user_stack_bank,
    input  wire logic [7:0] system_stack_bank,
    input  wire logic [7:0] condition_code_register,
    output logic      [23:0] rem_addr,
    output logic             rem_to_mem
);
    logic [15:0] low_addr;
    logic [15:0] rp_ofs;
    logic [3:0]  in_bank;
    logic [7:0]  bank_val;
    logic [4:0]  rp_eff;

    always_comb begin
        rp_eff = cmn_bank ? 5'h00 : reg_bank_ptr;
        // words sit at 2*i, bytes at 8+i within the 16-byte bank
        in_bank = is_word ? {reg_idx, 1'b0} : {1'b1, reg_idx};
        rp_ofs = 16'(rp_eff) * `PFX_BANK_STRIDE;
        low_addr = `PFX_REG_BASE + rp_ofs + {12'h000, in_bank}; // (RULE9) (RULE20)
        case (reg_idx[1:0]) // (RULE10)
            2'b10: bank_val = add_bank;
            2'b11: bank_val = condition_code_register[`PFX_CCR_S_BIT] ? system_stack_bank : user_stack_bank; // (RULE11) (RULE12)
            default: bank_val = data_bank;
        endcase
        rem_to_mem = (bank_val != `PFX_BANK_ZERO); // (RULE7) (RULE8)
        rem_addr = {bank_val, low_addr}; // (RULE8)
    end
endmodule : pfx_rem_addr

// ==== rtl/pfx_sequencer.sv ====
// Summary of operation
// (RULE1) no interrupt accepted after prefix or inhibit
// (RULE2) pending interrupt taken after next ordinary instruction
// (RULE3) level-mask, ccr or/and, status pop inhibit
// (RULE4) all six prefixes block interrupt acceptance
// (RULE5) prefix before inhibit applies to later instruction
// (RULE6) last conflicting bank prefix wins
// (RULE7) zero bank: remainder into operand register
// (RULE8) nonzero bank: remainder to bank:register address
// (RULE9) register address 0180 plus pointer*10 plus offset
// (RULE10) operand index picks data, additional, stack bank
// (RULE11) stack flag zero selects user stack bank
// (RULE12) stack flag one selects system stack bank
// (RULE13) four interrupt classes supported
// (RULE14) peripheral request starts its handler
// (RULE15) software interrupt instruction starts given vector
// (RULE16) auto-transfer shares hardware request path
// (RULE17) auto-transfer moves data then launches handler
// (RULE18) undefined opcode acts as vector ten
// (RULE19) freeze prefix keeps t,n,z,v,c unchanged
// (RULE20) common prefix forces register bank zero
`timescale 1ns/1ps
`include "pfx_consts.svh"

module pfx_sequencer #(
    parameter int XFER_CYCLES = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             op_valid,
    input  wire pfx_pkg::pfx_op_t op_code,
    input  wire logic [7:0]       op_vector,
    input  wire logic [2:0]       op_reg_idx,
    input  wire logic [4:0]       reg_bank_ptr,
    input  wire logic [7:0]       data_bank,
    input  wire logic [7:0]       add_bank,
    input  wire logic [7:0]       user_stack_bank,
    input  wire logic [7:0]       system_stack_bank,
    input  wire logic [7:0]       condition_code_register,
    input  wire logic             hw_irq_req,
    input  wire logic [7:0]       hw_irq_vector,
    input  wire logic             hw_irq_xfer,
    output logic                  op_ready,
    output logic                  irq_take,
    output pfx_pkg::pfx_irq_t     irq_class,
    output logic [7:0]            irq_vector,
    output logic                  xfer_busy,
    output pfx_pkg::pfx_bank_t    eff_bank,
    output logic                  eff_cmn_bank,
    output logic                  eff_flag_freeze,
    output logic [7:0]            ccr_keep_mask,
    output logic                  rem_valid,
    output logic                  rem_to_mem,
    output logic [23:0]           rem_addr
);
    import pfx_pkg::*;

    localparam logic [3:0] XFER_LAST = 4'(XFER_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // decode of the incoming instruction
    logic is_prefix;
    logic is_bank_pfx;
    logic is_inhibit;
    logic is_ordinary;
    logic fire;
    pfx_bank_t bank_of_op;

    assign fire = op_valid && op_ready;
    assign is_bank_pfx = (op_code == PFX_OP_PCB_P) || (op_code == PFX_OP_DATA_P) ||
                         (op_code == PFX_OP_ADD_P) || (op_code == PFX_OP_STK_P);
    assign is_prefix = is_bank_pfx || (op_code == PFX_OP_CMN_P) || (op_code == PFX_OP_FRZ_P); // (RULE4)
    assign is_inhibit = (op_code == PFX_OP_MOVLVL) || (op_code == PFX_OP_ORCC) ||
                        (op_code == PFX_OP_ANDCC) || (op_code == PFX_OP_POPSW); // (RULE3)
    assign is_ordinary = !is_prefix && !is_inhibit;

    always_comb begin
        case (op_code)
            PFX_OP_PCB_P:  bank_of_op = PFX_BANK_PROG;
            PFX_OP_DATA_P: bank_of_op = PFX_BANK_DATA;
            PFX_OP_ADD_P:  bank_of_op = PFX_BANK_ADD;
            PFX_OP_STK_P:  bank_of_op = PFX_BANK_STK;
            default:       bank_of_op = PFX_BANK_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // pending prefix state; inhibit instructions pass it through untouched
    pfx_bank_t pend_bank_r;
    logic      pend_cmn_r;
    logic      pend_frz_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_bank_r <= PFX_BANK_NONE;
            pend_cmn_r <= 1'b0;
            pend_frz_r <= 1'b0;
        end else if (fire) begin
            if (is_bank_pfx) begin
                pend_bank_r <= bank_of_op; // (RULE6)
            end else if (op_code == PFX_OP_CMN_P) begin
                pend_cmn_r <= 1'b1;
            end else if (op_code == PFX_OP_FRZ_P) begin
                pend_frz_r <= 1'b1;
            end else if (is_ordinary) begin
                pend_bank_r <= PFX_BANK_NONE;
                pend_cmn_r <= 1'b0;
                pend_frz_r <= 1'b0;
            end
            // inhibit: keep pending prefixes for the next instruction (RULE5)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prefix effect seen by the ordinary instruction being executed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eff_bank <= PFX_BANK_NONE;
            eff_cmn_bank <= 1'b0;
            eff_flag_freeze <= 1'b0;
            ccr_keep_mask <= 8'h00;
        end else if (fire) begin
            if (is_ordinary) begin
                eff_bank <= pend_bank_r; // (RULE5) (RULE6)
                eff_cmn_bank <= pend_cmn_r; // (RULE20)
                eff_flag_freeze <= pend_frz_r;
                ccr_keep_mask <= pend_frz_r ? `PFX_CCR_FLAG_MASK : 8'h00; // (RULE19)
            end else begin
                // inhibit instructions change ccr regardless of the freeze prefix
                eff_bank <= PFX_BANK_NONE;
                eff_cmn_bank <= 1'b0;
                eff_flag_freeze <= 1'b0;
                ccr_keep_mask <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // boundary interrupt gate
    logic blocked_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blocked_r <= 1'b0;
        end else if (fire) begin
            blocked_r <= !is_ordinary; // (RULE1) (RULE4)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt entry and auto-transfer service
    pfx_state_t state_r;
    logic [3:0] xfer_cnt_r;
    logic [7:0] xfer_vec_r;
    logic       hw_ok;

    // hardware request is only sampled at an ordinary instruction boundary
    assign hw_ok = fire && is_ordinary && hw_irq_req; // (RULE2) (RULE14) (RULE16)

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= PFX_ST_RUN;
            xfer_cnt_r <= 4'h0;
            xfer_vec_r <= 8'h00;
        end else begin
            case (state_r)
                PFX_ST_RUN: begin
                    if (hw_ok && hw_irq_xfer && (op_code != PFX_OP_UNDEF) && (op_code != PFX_OP_SWINT)) begin
                        state_r <= PFX_ST_XFER; // (RULE16)
                        xfer_cnt_r <= 4'h0;
                        xfer_vec_r <= hw_irq_vector;
                    end
                end
                PFX_ST_XFER: begin
                    if (xfer_cnt_r == XFER_LAST) begin
                        state_r <= PFX_ST_RUN; // (RULE17)
                    end else begin
                        xfer_cnt_r <= xfer_cnt_r + 4'h1;
                    end
                end
                default: state_r <= PFX_ST_RUN;
            endcase
        end
    end

    // stall the stream while a transfer is running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_ready <= 1'b1;
            xfer_busy <= 1'b0;
        end else begin
            op_ready <= !((state_r == PFX_ST_RUN && hw_ok && hw_irq_xfer &&
                           op_code != PFX_OP_UNDEF && op_code != PFX_OP_SWINT) ||
                          (state_r == PFX_ST_XFER && xfer_cnt_r != XFER_LAST));
            xfer_busy <= (state_r == PFX_ST_XFER) && (xfer_cnt_r != XFER_LAST);
        end
    end

    // one-cycle handler launch; own instruction events outrank the hardware request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_take <= 1'b0;
            irq_class <= PFX_IRQ_NONE;
            irq_vector <= 8'h00;
        end else begin
            irq_take <= 1'b0;
            irq_class <= PFX_IRQ_NONE;
            if (state_r == PFX_ST_XFER && xfer_cnt_r == XFER_LAST) begin
                irq_take <= 1'b1;
                irq_class <= PFX_IRQ_XFER; // (RULE13) (RULE17)
                irq_vector <= xfer_vec_r;
            end else if (fire && op_code == PFX_OP_UNDEF) begin
                irq_take <= 1'b1;
                irq_class <= PFX_IRQ_EXC;
                irq_vector <= `PFX_EXC_VECTOR; // (RULE18)
            end else if (fire && op_code == PFX_OP_SWINT) begin
                irq_take <= 1'b1;
                irq_class <= PFX_IRQ_SW;
                irq_vector <= op_vector; // (RULE15)
            end else if (state_r == PFX_ST_RUN && hw_ok && !blocked_r && !hw_irq_xfer) begin
                irq_take <= 1'b1;
                irq_class <= PFX_IRQ_HW; // (RULE13) (RULE14)
                irq_vector <= hw_irq_vector;
            end else if (state_r == PFX_ST_RUN && hw_ok && blocked_r && !hw_irq_xfer) begin
                // the instruction after a prefix/inhibit has now run (RULE2)
                irq_take <= 1'b1;
                irq_class <= PFX_IRQ_HW;
                irq_vector <= hw_irq_vector;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divide remainder destination
    logic        is_div;
    logic [23:0] addr_c;
    logic        to_mem_c;

    assign is_div = fire && ((op_code == PFX_OP_DIVB) || (op_code == PFX_OP_WORD_QUOTIENT_OP));

    pfx_rem_addr u_rem (
        .is_word           (op_code == PFX_OP_WORD_QUOTIENT_OP),
        .reg_idx           (op_reg_idx),
        .reg_bank_ptr      (reg_bank_ptr),
        .cmn_bank          (pend_cmn_r),
        .data_bank         (data_bank),
        .add_bank          (add_bank),
        .user_stack_bank   (user_stack_bank),
        .system_stack_bank (system_stack_bank),
        .condition_code_register               (condition_code_register),
        .rem_addr          (addr_c),
        .rem_to_mem        (to_mem_c)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rem_valid <= 1'b0;
            rem_to_mem <= 1'b0;
            rem_addr <= 24'h000000;
        end else begin
            rem_valid <= is_div;
            if (is_div) begin
                rem_to_mem <= to_mem_c; // (RULE7) (RULE8)
                rem_addr <= addr_c; // (RULE10)
            end
        end
    end

endmodule : pfx_sequencer

// ==== bench/pfx_seq_monitor.sv ====
`timescale 1ns/1ps
module pfx_seq_monitor #(
    parameter int XFER_CYCLES = 4
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               op_valid,
    input wire logic               op_ready,
    input wire pfx_pkg::pfx_op_t   op_code,
    input wire logic [7:0]         op_vector,
    input wire logic               hw_irq_req,
    input wire logic [7:0]         hw_irq_vector,
    input wire logic               hw_irq_xfer,
    input wire logic               irq_take,
    input wire pfx_pkg::pfx_irq_t  irq_class,
    input wire logic [7:0]         irq_vector,
    input wire logic               xfer_busy,
    input wire pfx_pkg::pfx_bank_t eff_bank,
    input wire logic               eff_flag_freeze,
    input wire logic [7:0]         ccr_keep_mask,
    input wire logic               rem_valid,
    input wire logic               rem_to_mem,
    input wire logic [23:0]        rem_addr
);
    import pfx_pkg::*;
    localparam int XD = XFER_CYCLES + 1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire tk = op_valid && op_ready;
    wire hold_op = tk && (op_code inside {[PFX_OP_PCB_P:PFX_OP_POPSW]});
    wire hw_op = tk && op_code == PFX_OP_PLAIN && hw_irq_req;
    ////////////////////
    no_take_hold_a: assert property (hold_op |=> !irq_take) else $error("interrupt taken after hold op");
    hw_accept_a: assert property (hw_op && !hw_irq_xfer |=> irq_take && irq_class == PFX_IRQ_HW
        && irq_vector == $past(hw_irq_vector)) else $error("hardware request not taken");
    xfer_start_a: assert property (hw_op && hw_irq_xfer |=> !op_ready && !irq_take ##1 xfer_busy)
        else $error("transfer not started");
    xfer_done_a: assert property (hw_op && hw_irq_xfer |-> ##[XD:XD] irq_take && irq_class == PFX_IRQ_XFER)
        else $error("transfer handler launch late");
    sw_vector_a: assert property (tk && op_code == PFX_OP_SWINT |=> irq_take && irq_class == PFX_IRQ_SW
        && irq_vector == $past(op_vector)) else $error("software interrupt wrong");
    exc_vector_a: assert property (tk && op_code == PFX_OP_UNDEF |=> irq_take && irq_class == PFX_IRQ_EXC
        && irq_vector == 8'h0a) else $error("exception wrong");
    div_rem_a: assert property (tk && (op_code inside {PFX_OP_DIVB, PFX_OP_WORD_QUOTIENT_OP}) |=> rem_valid)
        else $error("remainder missing");
    rem_dest_a: assert property (rem_valid |-> rem_to_mem == (rem_addr[23:16] != 8'h00))
        else $error("remainder destination wrong");
    freeze_mask_a: assert property (ccr_keep_mask == (eff_flag_freeze ? 8'h1f : 8'h00))
        else $error("flag keep mask wrong");
    last_bank_a: assert property (tk && op_code == PFX_OP_DATA_P ##1 tk && op_code == PFX_OP_PCB_P
        ##1 tk && op_code == PFX_OP_PLAIN |=> eff_bank == PFX_BANK_PROG) else $error("bank prefix order");
    cov_xfer_c: cover property (irq_take && irq_class == PFX_IRQ_XFER);
    cov_exc_c: cover property (irq_take && irq_class == PFX_IRQ_EXC);
    cov_mem_c: cover property (rem_valid && rem_to_mem);
endmodule : pfx_seq_monitor

bind pfx_sequencer pfx_seq_monitor #(.XFER_CYCLES(XFER_CYCLES)) pfx_seq_monitor_inst (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_vector(op_vector), .hw_irq_req(hw_irq_req), .hw_irq_vector(hw_irq_vector),
    .hw_irq_xfer(hw_irq_xfer), .irq_take(irq_take), .irq_class(irq_class), .irq_vector(irq_vector),
    .xfer_busy(xfer_busy), .eff_bank(eff_bank), .eff_flag_freeze(eff_flag_freeze),
    .ccr_keep_mask(ccr_keep_mask), .rem_valid(rem_valid), .rem_to_mem(rem_to_mem), .rem_addr(rem_addr));

// ==== bench/pfx_irq_src.sv ====
`timescale 1ns/1ps
module pfx_irq_src (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              raise,
    input wire logic [7:0]        raise_vec,
    input wire logic              raise_xfer,
    input wire logic              irq_take,
    input wire pfx_pkg::pfx_irq_t irq_class,
    output logic                  hw_irq_req,
    output logic [7:0]            hw_irq_vector,
    output logic                  hw_irq_xfer
);
    import pfx_pkg::*;
    // request stays up until the sequencer acknowledges it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hw_irq_req    <= 1'b0;
            hw_irq_vector <= 8'h00;
            hw_irq_xfer   <= 1'b0;
        end else if (raise) begin
            hw_irq_req    <= 1'b1;
            hw_irq_vector <= raise_vec;
            hw_irq_xfer   <= raise_xfer;
        end else if (irq_take && (irq_class inside {PFX_IRQ_HW, PFX_IRQ_XFER})) begin
            hw_irq_req <= 1'b0;
        end else if (!hw_irq_req) begin
            // idle lines toggle so no stale vector can look valid
            hw_irq_vector <= ~hw_irq_vector;
            hw_irq_xfer   <= ~hw_irq_xfer;
        end
    end
endmodule : pfx_irq_src

// ==== bench/pfx_sequencer_tb.sv ====
`timescale 1ns/1ps
module pfx_sequencer_tb;
    import pfx_pkg::*;
    localparam int XC = 3;
    logic clk, rst, op_valid, raise, raise_xfer, hw_irq_req, hw_irq_xfer;
    logic op_ready, irq_take, xfer_busy, eff_cmn_bank, eff_flag_freeze, rem_valid, rem_to_mem;
    logic [7:0] op_vector, data_bank, add_bank, user_stack_bank, system_stack_bank, condition_code_register;
    logic [7:0] raise_vec, hw_irq_vector, irq_vector, ccr_keep_mask;
    logic [2:0] op_reg_idx;
    logic [4:0] reg_bank_ptr;
    logic [23:0] rem_addr;
    pfx_op_t op_code;
    pfx_irq_t irq_class;
    pfx_bank_t eff_bank;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    pfx_sequencer #(.XFER_CYCLES(XC)) pfx_sequencer_inst (
        .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_vector(op_vector),
        .op_reg_idx(op_reg_idx), .reg_bank_ptr(reg_bank_ptr), .data_bank(data_bank), .add_bank(add_bank),
        .user_stack_bank(user_stack_bank), .system_stack_bank(system_stack_bank), .condition_code_register(condition_code_register),
        .hw_irq_req(hw_irq_req), .hw_irq_vector(hw_irq_vector), .hw_irq_xfer(hw_irq_xfer),
        .op_ready(op_ready), .irq_take(irq_take), .irq_class(irq_class), .irq_vector(irq_vector),
        .xfer_busy(xfer_busy), .eff_bank(eff_bank), .eff_cmn_bank(eff_cmn_bank),
        .eff_flag_freeze(eff_flag_freeze), .ccr_keep_mask(ccr_keep_mask), .rem_valid(rem_valid),
        .rem_to_mem(rem_to_mem), .rem_addr(rem_addr));
    pfx_irq_src pfx_irq_src_inst (
        .clk(clk), .rst(rst), .raise(raise), .raise_vec(raise_vec), .raise_xfer(raise_xfer),
        .irq_take(irq_take), .irq_class(irq_class), .hw_irq_req(hw_irq_req),
        .hw_irq_vector(hw_irq_vector), .hw_irq_xfer(hw_irq_xfer));
    ////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    // returns just after the take edge, with this op's answer already showing
    task automatic issue(input pfx_op_t op, input logic [7:0] v, input logic [2:0] idx);
        op_valid   <= 1'b1;
        op_code    <= op;
        op_vector  <= v;
        op_reg_idx <= idx;
        @(negedge clk);
        while (op_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        #1;
    endtask : issue
    task automatic idle;
        op_valid <= 1'b0;
        @(posedge clk);
        #1;
    endtask : idle
    task automatic raise_irq(input logic [7:0] v, input logic x);
        raise      <= 1'b1;
        raise_vec  <= v;
        raise_xfer <= x;
        @(posedge clk);
        raise <= 1'b0;
        #1;
    endtask : raise_irq
    function automatic pfx_bank_t bank_of(input int p);
        case (p)
            1: return PFX_BANK_PROG;
            2: return PFX_BANK_DATA;
            3: return PFX_BANK_ADD;
            4: return PFX_BANK_STK;
            default: return PFX_BANK_NONE;
        endcase
    endfunction : bank_of
    function automatic logic [31:0] exp_rem(input logic w, input logic [2:0] i, input logic [4:0] rp);
        logic [7:0] b;
        logic [15:0] a;
        case (i[1:0])
            2'h2: b = add_bank;
            2'h3: b = condition_code_register[5] ? system_stack_bank : user_stack_bank;
            default: b = data_bank;
        endcase
        a = 16'h0180 + {7'h00, rp, 4'h0} + (w ? {12'h000, i, 1'b0} : {13'h0001, i});
        return {6'h00, 1'b1, b != 8'h00, b, a};
    endfunction : exp_rem
    ////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        int k;
        rst = 1'b1; op_valid = 1'b0; op_code = PFX_OP_PLAIN; op_vector = 8'h00; op_reg_idx = 3'h0;
        raise = 1'b0; raise_vec = 8'h00; raise_xfer = 1'b0; reg_bank_ptr = 5'h03; condition_code_register = 8'h00;
        data_bank = 8'h53; add_bank = 8'h00; user_stack_bank = 8'h21; system_stack_bank = 8'h3c;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({op_ready, irq_take, rem_valid, eff_bank}, {1'b1, 1'b0, 1'b0, PFX_BANK_NONE});
        for (int i = 1; i <= 6; i++) begin
            raise_irq(8'h20 + 8'(i), 1'b0);
            issue(pfx_op_t'(i), 8'h00, 3'h0);
            chk(irq_take, 1'b0);
            issue(pfx_op_t'(7 + i % 4), 8'h00, 3'h0);
            chk(irq_take, 1'b0);
            issue(PFX_OP_PLAIN, 8'h00, 3'h0);
            chk({irq_take, irq_class, irq_vector}, {1'b1, PFX_IRQ_HW, 8'h20 + 8'(i)});
            chk({eff_bank, eff_cmn_bank, eff_flag_freeze}, {bank_of(i), i == 5, i == 6});
            chk(ccr_keep_mask, i == 6 ? 8'h1f : 8'h00);
            // let the requester see the take before the next instruction
            idle();
        end
        issue(PFX_OP_ADD_P, 8'h00, 3'h0);
        issue(PFX_OP_DATA_P, 8'h00, 3'h0);
        issue(PFX_OP_PCB_P, 8'h00, 3'h0);
        issue(PFX_OP_PLAIN, 8'h00, 3'h0);
        idle();
        chk(eff_bank, PFX_BANK_PROG);
        raise_irq(8'h2b, 1'b0);
        issue(PFX_OP_UNDEF, 8'h00, 3'h0);
        chk({irq_take, irq_class, irq_vector}, {1'b1, PFX_IRQ_EXC, 8'h0a});
        idle();
        issue(PFX_OP_SWINT, 8'h5c, 3'h0);
        chk({irq_take, irq_class, irq_vector}, {1'b1, PFX_IRQ_SW, 8'h5c});
        idle();
        issue(PFX_OP_PLAIN, 8'h00, 3'h0);
        chk({irq_take, irq_class, irq_vector}, {1'b1, PFX_IRQ_HW, 8'h2b});
        idle();
        raise_irq(8'h1d, 1'b1);
        issue(PFX_OP_PLAIN, 8'h00, 3'h0);
        idle();
        chk({xfer_busy, op_ready, irq_take}, {1'b1, 1'b0, 1'b0});
        k = 1;
        while (irq_take !== 1'b1 && k < 20) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(k, XC);
        chk({irq_class, irq_vector}, {PFX_IRQ_XFER, 8'h1d});
        // request drops one edge after the launch; no instruction may meet it
        idle();
        for (int n = 0; n < 16; n++) begin
            condition_code_register <= {2'h0, n[3], 5'h00};
            issue(n[3] ? PFX_OP_WORD_QUOTIENT_OP : PFX_OP_DIVB, 8'h00, n[2:0]);
            chk({rem_valid, rem_to_mem, rem_addr}, exp_rem(n[3], n[2:0], 5'h03));
            idle();
        end
        issue(PFX_OP_CMN_P, 8'h00, 3'h0);
        issue(PFX_OP_DIVB, 8'h00, 3'h1);
        chk({rem_valid, rem_to_mem, rem_addr}, exp_rem(1'b0, 3'h1, 5'h00));
        idle();
        results();
    end
endmodule : pfx_sequencer_tb
